// File: include/ubd_pkg.sv
package ubd_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_BAUD_DIV = 3'h1;
    localparam logic [2:0] OFS_CTRL_TWO = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_IRQ_STS = 3'h4;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h5;
    // Control two fields
    localparam int BIT_EMPTY_EN = 0;
    localparam int BIT_IDLE_EN = 1;
    localparam int BIT_SPEED = 2;
    // Status fields
    localparam int BIT_ST_EMPTY = 0;
    localparam int BIT_ST_IDLE = 1;
    localparam int BIT_ST_RX_READY = 2;
    localparam int BIT_ST_REQ = 3;
    // Interrupt status / mask fields
    localparam int BIT_IRQ_TX = 0;
    localparam int BIT_IRQ_RX = 1;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CTRL_TWO = 3'h0;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // Oversampling counts per bit, less one
    localparam logic [5:0] OS_LOW_LAST = 6'h3f;
    localparam logic [5:0] OS_HIGH_LAST = 6'h0f;
    localparam logic [2:0] LAST_BIT = 3'h7;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } ubd_tx_state_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } ubd_rx_state_t;
endpackage

// File: hw/ubd_uart.sv
`timescale 1ns/1ps
module ubd_uart #(
    parameter int DIV_W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ubd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ubd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ubd_pkg::DATA_W-1:0] reg_rdata,
    output logic txd,
    input wire logic rxd,
    output logic tx_idle_flag,
    output logic tx_empty_flag,
    output logic serial_irq_req,
    output logic irq
);
    import ubd_pkg::*;

    // Divisor is one byte wide by definition
    if (DIV_W != 8) begin : g_bad_div
        $error("DIV_W must be 8");
    end

    logic [7:0] rd_data_reg;
    logic txd_reg;
    logic tx_idle_flag_reg;
    logic tx_empty_flag_reg;
    logic req_reg;
    logic irq_reg;
    logic [7:0] baud_divisor_reg;
    logic [2:0] ctrl_two_reg;
    logic [7:0] hold_reg;
    logic [7:0] rx_data_reg;
    logic rx_ready_reg;
    logic [1:0] irq_sts_reg;
    logic [1:0] irq_mask_reg;
    logic [7:0] presc_reg;
    ubd_tx_state_t tx_state_reg;
    logic [5:0] tx_os_reg;
    logic [7:0] tx_shift_reg;
    logic [2:0] tx_bit_reg;
    ubd_rx_state_t rx_state_reg;
    logic [5:0] rx_os_reg;
    logic [7:0] rx_shift_reg;
    logic [2:0] rx_bit_reg;
    logic rx_sync1_reg;
    logic rx_sync2_reg;
    logic data_wr;
    logic data_rd;
    logic presc_tick;
    logic [5:0] os_last;
    logic tx_bit_end;
    logic tx_load;
    logic rx_done;
    logic req_cond;

    assign reg_rdata = rd_data_reg;
    assign txd = txd_reg;
    assign tx_idle_flag = tx_idle_flag_reg;
    assign tx_empty_flag = tx_empty_flag_reg;
    assign serial_irq_req = req_reg;
    assign irq = irq_reg;

    // Qualified bus strobes
    assign data_wr = ce && reg_wr && (reg_addr == OFS_DATA);
    assign data_rd = ce && reg_rd && (reg_addr == OFS_DATA);

    assign os_last = ctrl_two_reg[BIT_SPEED] ? OS_HIGH_LAST : OS_LOW_LAST;
    assign presc_tick = ce && (presc_reg == baud_divisor_reg);
    assign tx_bit_end = presc_tick && (tx_os_reg == os_last);
    assign tx_load = ce && (tx_state_reg == TX_IDLE) && !tx_empty_flag_reg;
    assign rx_done = presc_tick && (rx_state_reg == RX_STOP) && (rx_os_reg == os_last)
        && rx_sync2_reg;

    assign req_cond = (ctrl_two_reg[BIT_IDLE_EN] && tx_idle_flag_reg)
        || (ctrl_two_reg[BIT_EMPTY_EN] && tx_empty_flag_reg);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            baud_divisor_reg <= RST_BYTE;
            ctrl_two_reg <= RST_CTRL_TWO;
            irq_mask_reg <= RST_IRQ;
        end else if (ce && reg_wr) begin
            if (reg_addr == OFS_BAUD_DIV) begin
                baud_divisor_reg <= reg_wdata;
            end
            if (reg_addr == OFS_CTRL_TWO) begin
                ctrl_two_reg <= reg_wdata[2:0];
            end
            if (reg_addr == OFS_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= RST_BYTE;
        end else if (ce) begin
            presc_reg <= (presc_reg == baud_divisor_reg) ? RST_BYTE : presc_reg + 8'h01;
        end
    end

    // Transmit holding side of the data register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= RST_BYTE;
            tx_empty_flag_reg <= 1'b1;
        end else if (data_wr) begin
            // A write beside a load keeps the buffer full
            hold_reg <= reg_wdata;
            tx_empty_flag_reg <= 1'b0;
        end else if (tx_load) begin
            tx_empty_flag_reg <= 1'b1;
        end
    end

    // Transmit shifter, 8N1, line high at rest
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_os_reg <= 6'h00;
            tx_shift_reg <= RST_BYTE;
            tx_bit_reg <= 3'h0;
            txd_reg <= 1'b1;
        end else if (ce) begin
            if (tx_state_reg != TX_IDLE && presc_tick) begin
                tx_os_reg <= tx_bit_end ? 6'h00 : tx_os_reg + 6'h01;
            end
            unique case (tx_state_reg)
                TX_IDLE: begin
                    tx_os_reg <= 6'h00;
                    if (tx_load) begin
                        tx_shift_reg <= hold_reg;
                        tx_bit_reg <= 3'h0;
                        txd_reg <= 1'b0;
                        tx_state_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        txd_reg <= tx_shift_reg[0];
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_reg == LAST_BIT) begin
                            txd_reg <= 1'b1;
                            tx_state_reg <= TX_STOP;
                        end else begin
                            txd_reg <= tx_shift_reg[1];
                            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Idle means shifter stopped and nothing waiting
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_idle_flag_reg <= 1'b1;
        end else if (ce) begin
            tx_idle_flag_reg <= (tx_state_reg == TX_IDLE) && tx_empty_flag_reg && !data_wr;
        end
    end

    // Two-flop synchroniser on the receive pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync1_reg <= 1'b1;
            rx_sync2_reg <= 1'b1;
        end else if (ce) begin
            rx_sync1_reg <= rxd;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    // Receiver; start bit is rechecked at mid-bit to reject glitches
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg <= 6'h00;
            rx_shift_reg <= RST_BYTE;
            rx_bit_reg <= 3'h0;
        end else if (ce) begin
            unique case (rx_state_reg)
                RX_IDLE: begin
                    rx_os_reg <= 6'h00;
                    if (!rx_sync2_reg) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (presc_tick) begin
                        if (rx_os_reg == {1'b0, os_last[5:1]}) begin
                            rx_os_reg <= 6'h00;
                            rx_bit_reg <= 3'h0;
                            rx_state_reg <= rx_sync2_reg ? RX_IDLE : RX_DATA;
                        end else begin
                            rx_os_reg <= rx_os_reg + 6'h01;
                        end
                    end
                end
                RX_DATA: begin
                    if (presc_tick) begin
                        if (rx_os_reg == os_last) begin
                            rx_os_reg <= 6'h00;
                            rx_shift_reg <= {rx_sync2_reg, rx_shift_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 3'h1;
                            if (rx_bit_reg == LAST_BIT) begin
                                rx_state_reg <= RX_STOP;
                            end
                        end else begin
                            rx_os_reg <= rx_os_reg + 6'h01;
                        end
                    end
                end
                RX_STOP: begin
                    if (presc_tick) begin
                        if (rx_os_reg == os_last) begin
                            rx_state_reg <= RX_IDLE;
                        end else begin
                            rx_os_reg <= rx_os_reg + 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    // Receive side of the data register; bad stop bit drops the byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_reg <= RST_BYTE;
            rx_ready_reg <= 1'b0;
        end else if (rx_done) begin
            // New byte wins over a read in the same cycle
            rx_data_reg <= rx_shift_reg;
            rx_ready_reg <= 1'b1;
        end else if (data_rd) begin
            rx_ready_reg <= 1'b0;
        end
    end

    // Shared request flag follows any enabled source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= 1'b0;
        end else if (ce) begin
            req_reg <= req_cond;
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_sts_reg <= RST_IRQ;
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_sts_reg[BIT_IRQ_TX] <= req_cond || (irq_sts_reg[BIT_IRQ_TX]
                && !(reg_wr && reg_addr == OFS_IRQ_STS && reg_wdata[BIT_IRQ_TX]));
            irq_sts_reg[BIT_IRQ_RX] <= rx_done || (irq_sts_reg[BIT_IRQ_RX]
                && !(reg_wr && reg_addr == OFS_IRQ_STS && reg_wdata[BIT_IRQ_RX]));
            irq_reg <= |(irq_sts_reg & irq_mask_reg);
        end
    end

    // Read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= RST_BYTE;
        end else if (ce) begin
            rd_data_reg <= RST_BYTE;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFS_DATA: rd_data_reg <= rx_data_reg;
                    OFS_BAUD_DIV: rd_data_reg <= baud_divisor_reg;
                    OFS_CTRL_TWO: rd_data_reg <= {5'h00, ctrl_two_reg};
                    OFS_STATUS: rd_data_reg <= {4'h0, req_reg, rx_ready_reg,
                        tx_idle_flag_reg, tx_empty_flag_reg};
                    OFS_IRQ_STS: rd_data_reg <= {6'h00, irq_sts_reg};
                    OFS_IRQ_MASK: rd_data_reg <= {6'h00, irq_mask_reg};
                    default: rd_data_reg <= RST_BYTE;
                endcase
            end
        end
    end
endmodule

// File: sim/ubd_checker.sv
`timescale 1ns/1ps
module ubd_checker (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ubd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ubd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ubd_pkg::DATA_W-1:0] reg_rdata,
    input wire logic txd,
    input wire logic tx_idle_flag,
    input wire logic tx_empty_flag,
    input wire logic serial_irq_req,
    input wire logic irq
);
    import ubd_pkg::*;
    logic [2:0] ctrl_reg;
    logic [7:0] div_reg;
    logic txd_reg;
    int run_reg;
    int blen;
    logic cond;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of the config writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= RST_CTRL_TWO;
            div_reg <= RST_BYTE;
        end else if (ce && reg_wr && reg_addr == OFS_CTRL_TWO) begin
            ctrl_reg <= reg_wdata[2:0];
        end else if (ce && reg_wr && reg_addr == OFS_BAUD_DIV) begin
            div_reg <= reg_wdata;
        end
    end
    // Run length of the line level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txd_reg <= 1'b1;
            run_reg <= 0;
        end else begin
            txd_reg <= txd;
            run_reg <= (txd != txd_reg) ? 1 : run_reg + 1;
        end
    end
    // Int math: divisor plus one would wrap in 8 bits
    assign blen = (ctrl_reg[BIT_SPEED] ? 16 : 64) * (int'(div_reg) + 1);
    assign cond = (ctrl_reg[1] && tx_idle_flag) || (ctrl_reg[0] && tx_empty_flag);
    a_req_idle_on: assert property (ctrl_reg[1] && tx_idle_flag |=> serial_irq_req)
        else $error("idle request missing");
    a_req_idle_off: assert property (!ctrl_reg[1] && !(ctrl_reg[0] && tx_empty_flag)
        |=> !serial_irq_req) else $error("idle request not gated");
    a_req_empty_on: assert property (ctrl_reg[0] && tx_empty_flag |=> serial_irq_req)
        else $error("empty request missing");
    a_req_empty_off: assert property (!ctrl_reg[0] && !(ctrl_reg[1] && tx_idle_flag)
        |=> !serial_irq_req) else $error("empty request not gated");
    a_req_any_src: assert property (serial_irq_req == $past(cond))
        else $error("request differs from sources");
    a_rd_data_stands: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_baud_read_back: assert property (reg_rd && reg_addr == OFS_BAUD_DIV
        |=> reg_rdata == div_reg) else $error("divisor read back wrong");
    // Start bit may be short by the divisor, all others whole periods
    a_bit_period_grid: assert property ($rose(txd)
        |-> (run_reg + div_reg) % blen <= div_reg) else $error("bit period wrong");
    c_frame: cover property ($fell(txd));
    c_req: cover property ($rose(serial_irq_req));
    c_irq: cover property ($rose(irq));
endmodule
bind ubd_uart ubd_checker chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txd(txd), .tx_idle_flag(tx_idle_flag), .tx_empty_flag(tx_empty_flag),
    .serial_irq_req(serial_irq_req), .irq(irq));

// File: sim/ubd_peer.sv
`timescale 1ns/1ps
module ubd_peer (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd,
    input wire logic [15:0] blen,
    output logic [7:0] got
);
    initial begin
        rxd = 1'b1;
        got = 8'h00;
    end
    // Centre sampling tolerates a short start bit
    always @(negedge txd) begin
        repeat (blen / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (blen) @(posedge mclk);
            got[i] = txd;
        end
        repeat (blen) @(posedge mclk);
    end
    // One frame: start low, LSB first, stop high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            rxd <= f[i];
            repeat (blen - 1) @(posedge mclk);
        end
    endtask
endmodule

// File: sim/uart_tx_irq_baud_data_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module uart_tx_irq_baud_data_tb;
    import ubd_pkg::*;
    logic mclk, rst_n, ce, reg_wr, reg_rd, rxd, txd, tx_idle_flag, tx_empty_flag;
    logic serial_irq_req, irq;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, got, d, b;
    logic [15:0] blen;
    int fails, n_checks, seed;
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    ubd_uart dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .txd(txd), .rxd(rxd), .tx_idle_flag(tx_idle_flag), .tx_empty_flag(tx_empty_flag),
        .serial_irq_req(serial_irq_req), .irq(irq));
    ubd_peer peer (.mclk(mclk), .txd(txd), .rxd(rxd), .blen(blen), .got(got));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        v = reg_rdata;
    endtask
    // Poll a status bit, bounded
    task automatic wait_st(input int bitn, input logic v);
        for (int i = 0; i < 8000; i++) begin
            rd(OFS_STATUS, d);
            if (d[bitn] === v) return;
        end
        fails++;
        close_out();
    endtask
    // Model of the shared request
    task automatic gate(input logic k, input logic idl);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_CTRL_TWO, {5'h00, k, e[1:0]});
            rd(OFS_STATUS, d);
            `CHK("req", (e[1] & idl) | e[0], serial_irq_req)
        end
        wr(OFS_CTRL_TWO, {5'h00, k, 2'b00});
    endtask
    task automatic irq_step(input logic [2:0] a, input logic [7:0] v, input logic e);
        wr(a, v);
        rd(OFS_IRQ_STS, d);
        `CHK("irq", e, irq)
    endtask
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        blen = 16'h0040;
        seed = $urandom(27);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_STATUS, d);
        `CHK("status", 8'h03, d)
        rd(3'h6, d);
        `CHK("unmapped", 8'h00, d)
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            wr(OFS_BAUD_DIV, b);
            rd(OFS_BAUD_DIV, d);
            `CHK("baud", b, d)
        end
        // Clock enable low: the write is ignored, divisor holds
        @(posedge mclk);
        ce <= 1'b0;
        wr(OFS_BAUD_DIV, ~b);
        ce <= 1'b1;
        rd(OFS_BAUD_DIV, d);
        `CHK("ce_hold", b, d)
        for (int k = 0; k < 2; k++) begin
            // Speed select and divisor both set by software
            // rate setup
            wr(OFS_BAUD_DIV, k ? 8'h02 : 8'h01);
            wr(OFS_CTRL_TWO, {5'h00, k[0], 2'b00});
            blen = k ? 16'd48 : 16'd128;
            repeat (300) @(posedge mclk);
            b = 8'($urandom);
            wr(OFS_DATA, b);
            wait_st(BIT_ST_IDLE, 0);
            `CHK("st_frame", 8'h01, d & 8'h07)
            `CHK("empty_pin", 1'b1, tx_empty_flag)
            if (k == 0) gate(1'b0, 1'b0);
            wait_st(BIT_ST_IDLE, 1);
            `CHK("tx_byte", b, got)
            `CHK("idle_pin", 1'b1, tx_idle_flag)
            if (k == 0) begin
                gate(1'b0, 1'b1);
                irq_step(OFS_IRQ_MASK, 8'h01, 1'b1);
                irq_step(OFS_IRQ_STS, 8'h01, 1'b0);
            end
            peer.send(~b);
            wait_st(BIT_ST_RX_READY, 1);
            rd(OFS_DATA, d);
            `CHK("rx_byte", ~b, d)
            irq_step(OFS_IRQ_MASK, 8'h02, 1'b1);
            irq_step(OFS_IRQ_STS, 8'h02, 1'b0);
            `CHK("irq_sts", 8'h00, d)
        end
        close_out();
    end
endmodule
